// File: core/ucfw_device.sv
// device end: wake-up handshake, packet framer and parser, transparent bypass
`timescale 1ns/100ps
`default_nettype none
module ucfw_device (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // link to host
  ucfw_link_if.dev         LINK,
  // packet send request
  input  wire logic        EVT_VALID,
  input  wire logic [7:0]  EVT_TYPE,
  input  wire logic [7:0]  EVT_OPCODE,
  input  wire logic [15:0] EVT_LEN,
  output logic             EVT_READY,
  // payload or raw bytes out
  input  wire logic [7:0]  PAY_DATA,
  input  wire logic        PAY_VALID,
  output logic             PAY_READY,
  // received packets
  output logic             RX_HDR_VALID,
  output logic [7:0]       RX_TYPE,
  output logic [7:0]       RX_OPCODE,
  output logic [15:0]      RX_LEN,
  output logic [7:0]       RX_DATA,
  output logic             RX_DATA_VALID,
  output logic             RX_END_OK,
  output logic             RX_DROP,
  // mode control and status
  input  wire logic        TL_DISABLE,
  input  wire logic        GO_TRANSPARENT,
  output logic             TL_ENABLED,
  output logic             TRANSPARENT
);

  typedef enum logic [1:0] {W_ON, W_DRAIN, W_OFF, W_WAIT} ucfw_wake_t;

  ucfw_wake_t        wst_ff, nxt_wst;
  ucfw_pkg::ucfw_tx_t tst_ff;
  ucfw_pkg::ucfw_rx_t rst_ff;
  logic              cts_s1_ff, cts_s2_ff, cts_s3_ff;
  logic              rts_on_ff, cfm_pend_ff, cfm_set, trans_ff;
  logic [7:0]        typ_ff, op_ff, sum_ff, tx_byte;
  logic [15:0]       len_ff, cnt_ff, rlen_ff, rcnt_ff, len_c;
  logic [7:0]        rtyp_ff, rop_ff;
  logic              tl_on, hdr_go, cfm_go, fire, rx_take;
  logic [7:0]        rx_b;

  ////////////////////////////////////////////////////////////////////////
  // cts pin synchroniser; third stage only feeds the edge detector
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cts_s1_ff <= 1'b1;
      cts_s2_ff <= 1'b1;
      cts_s3_ff <= 1'b1;
    end else begin
      cts_s1_ff <= LINK.host_rts_n;
      cts_s2_ff <= cts_s1_ff;
      cts_s3_ff <= cts_s2_ff;
    end
  end

  // transport layer state
  assign tl_on = (wst_ff == W_ON) || (wst_ff == W_DRAIN);
  always_comb begin
    nxt_wst = wst_ff;
    cfm_set = 1'b0;
    case (wst_ff)
      W_ON: begin
        if (TL_DISABLE) begin
          nxt_wst = W_DRAIN;
        end
      end
      W_DRAIN: begin
        // pending confirm and any queued event go out before the link turns off
        if (tst_ff == ucfw_pkg::T_IDLE && !EVT_VALID && !cfm_pend_ff && !hdr_go) begin
          nxt_wst = W_OFF;
        end
      end
      W_OFF: begin
        if (cts_s3_ff && !cts_s2_ff) begin
          nxt_wst = W_ON;
          cfm_set = 1'b1;
        end else if (EVT_VALID || PAY_VALID) begin
          nxt_wst = W_WAIT;
        end
      end
      W_WAIT: begin
        if (!cts_s2_ff) begin
          nxt_wst = W_ON;
          cfm_set = 1'b1;
        end
      end
      default: nxt_wst = W_ON;
    endcase
  end

  // rts and wake line are asserted whenever the link is not fully off
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      wst_ff    <= W_ON;
      rts_on_ff <= 1'b1;
    end else begin
      wst_ff    <= nxt_wst;
      rts_on_ff <= (nxt_wst != W_OFF);
    end
  end
  assign LINK.dev_rts_n        = !rts_on_ff;
  assign LINK.host_wakeup_line = rts_on_ff;
  assign TL_ENABLED            = tl_on;

  // pending confirm; a new wake-up wins over the clear
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cfm_pend_ff <= 1'b0;
    end else begin
      cfm_pend_ff <= cfm_set || (cfm_pend_ff && !cfm_go);
    end
  end

  // transparent mode; a break clears it, break wins over entry
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      trans_ff <= 1'b0;
    end else if (LINK.line_break) begin
      trans_ff <= 1'b0;
    end else if (GO_TRANSPARENT && tl_on) begin
      trans_ff <= 1'b1;
    end
  end
  assign TRANSPARENT = trans_ff;

  ////////////////////////////////////////////////////////////////////////
  // transmit side: confirm goes ahead of any queued event
  assign cfm_go    = (tst_ff == ucfw_pkg::T_IDLE) && cfm_pend_ff && tl_on && !trans_ff;
  assign EVT_READY = (tst_ff == ucfw_pkg::T_IDLE) && !cfm_pend_ff && tl_on && !trans_ff;
  assign hdr_go    = cfm_go || (EVT_READY && EVT_VALID);
  assign PAY_READY = tl_on && (trans_ff || tst_ff == ucfw_pkg::T_DATA);
  assign len_c     = (EVT_LEN > ucfw_pkg::MAX_PAYLOAD) ? ucfw_pkg::MAX_PAYLOAD : EVT_LEN;

  // byte selection per framer state
  always_comb begin
    fire    = 1'b1;
    tx_byte = ucfw_pkg::START_BYTE;
    case (tst_ff)
      ucfw_pkg::T_IDLE: begin
        fire    = hdr_go || (trans_ff && tl_on && PAY_VALID);
        tx_byte = trans_ff ? PAY_DATA : ucfw_pkg::START_BYTE;
      end
      ucfw_pkg::T_TYPE: tx_byte = typ_ff;
      ucfw_pkg::T_OP:   tx_byte = op_ff;
      ucfw_pkg::T_LENL: tx_byte = len_ff[7:0];
      ucfw_pkg::T_LENH: tx_byte = len_ff[15:8];
      ucfw_pkg::T_SUM:  tx_byte = sum_ff;
      ucfw_pkg::T_DATA: begin
        fire    = PAY_VALID;
        tx_byte = PAY_DATA;
      end
      ucfw_pkg::T_END:  tx_byte = ucfw_pkg::END_BYTE;
      default:          fire = 1'b0;
    endcase
  end

  // framer sequence, one byte per cycle, payload paced by PAY_VALID
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tst_ff <= ucfw_pkg::T_IDLE;
      typ_ff <= 8'h00;
      op_ff  <= 8'h00;
      sum_ff <= 8'h00;
      len_ff <= ucfw_pkg::LEN_ZERO;
      cnt_ff <= ucfw_pkg::LEN_ZERO;
    end else begin
      case (tst_ff)
        ucfw_pkg::T_IDLE: begin
          if (hdr_go) begin
            tst_ff <= ucfw_pkg::T_TYPE;
            typ_ff <= cfm_go ? ucfw_pkg::TYPE_NOTIFY : EVT_TYPE;
            op_ff  <= cfm_go ? ucfw_pkg::OP_TL_ENABLED : EVT_OPCODE;
            len_ff <= cfm_go ? ucfw_pkg::LEN_ZERO : len_c;
            sum_ff <= cfm_go ? ucfw_pkg::hdr_sum(ucfw_pkg::TYPE_NOTIFY, ucfw_pkg::OP_TL_ENABLED,
                                                 ucfw_pkg::LEN_ZERO)
                             : ucfw_pkg::hdr_sum(EVT_TYPE, EVT_OPCODE, len_c);
            cnt_ff <= ucfw_pkg::LEN_ZERO;
          end
        end
        ucfw_pkg::T_TYPE: tst_ff <= ucfw_pkg::T_OP;
        ucfw_pkg::T_OP:   tst_ff <= ucfw_pkg::T_LENL;
        ucfw_pkg::T_LENL: tst_ff <= ucfw_pkg::T_LENH;
        ucfw_pkg::T_LENH: tst_ff <= ucfw_pkg::T_SUM;
        ucfw_pkg::T_SUM:  tst_ff <= (len_ff == ucfw_pkg::LEN_ZERO) ? ucfw_pkg::T_END : ucfw_pkg::T_DATA;
        ucfw_pkg::T_DATA: begin
          if (PAY_VALID) begin
            cnt_ff <= cnt_ff + ucfw_pkg::LEN_ONE;
            if (cnt_ff + ucfw_pkg::LEN_ONE == len_ff) begin
              tst_ff <= ucfw_pkg::T_END;
            end
          end
        end
        default: tst_ff <= ucfw_pkg::T_IDLE;
      endcase
    end
  end

  // registered link byte
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      LINK.d2h_byte  <= 8'h00;
      LINK.d2h_valid <= 1'b0;
    end else begin
      LINK.d2h_byte  <= tx_byte;
      LINK.d2h_valid <= fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive parser; bytes are ignored while the link is off
  assign rx_take = LINK.h2d_valid && tl_on;
  assign rx_b    = LINK.h2d_byte;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rst_ff        <= ucfw_pkg::R_HUNT;
      rtyp_ff       <= 8'h00;
      rop_ff        <= 8'h00;
      rlen_ff       <= ucfw_pkg::LEN_ZERO;
      rcnt_ff       <= ucfw_pkg::LEN_ZERO;
      RX_HDR_VALID  <= 1'b0;
      RX_DATA       <= 8'h00;
      RX_DATA_VALID <= 1'b0;
      RX_END_OK     <= 1'b0;
      RX_DROP       <= 1'b0;
    end else begin
      RX_HDR_VALID  <= 1'b0;
      RX_DATA_VALID <= 1'b0;
      RX_END_OK     <= 1'b0;
      RX_DROP       <= 1'b0;
      if (rx_take && trans_ff) begin
        RX_DATA       <= rx_b;
        RX_DATA_VALID <= 1'b1;
        rst_ff        <= ucfw_pkg::R_HUNT;
      end else if (rx_take) begin
        case (rst_ff)
          ucfw_pkg::R_HUNT: if (rx_b == ucfw_pkg::START_BYTE) rst_ff <= ucfw_pkg::R_TYPE;
          ucfw_pkg::R_TYPE: begin
            rtyp_ff <= rx_b;
            rst_ff  <= ucfw_pkg::R_OP;
          end
          ucfw_pkg::R_OP: begin
            rop_ff <= rx_b;
            rst_ff <= ucfw_pkg::R_LENL;
          end
          ucfw_pkg::R_LENL: begin
            rlen_ff[7:0] <= rx_b;
            rst_ff       <= ucfw_pkg::R_LENH;
          end
          ucfw_pkg::R_LENH: begin
            rlen_ff[15:8] <= rx_b;
            rst_ff        <= ucfw_pkg::R_SUM;
          end
          ucfw_pkg::R_SUM: begin
            // host may only send requests or replies
            if (rx_b != ucfw_pkg::hdr_sum(rtyp_ff, rop_ff, rlen_ff) || rlen_ff > ucfw_pkg::MAX_PAYLOAD ||
                (rtyp_ff != ucfw_pkg::TYPE_REQUEST && rtyp_ff != ucfw_pkg::TYPE_REPLY)) begin
              RX_DROP <= 1'b1;
              rst_ff  <= ucfw_pkg::R_HUNT;
            end else begin
              RX_HDR_VALID <= 1'b1;
              rcnt_ff      <= ucfw_pkg::LEN_ZERO;
              rst_ff       <= (rlen_ff == ucfw_pkg::LEN_ZERO) ? ucfw_pkg::R_END : ucfw_pkg::R_DATA;
            end
          end
          ucfw_pkg::R_DATA: begin
            RX_DATA       <= rx_b;
            RX_DATA_VALID <= 1'b1;
            rcnt_ff       <= rcnt_ff + ucfw_pkg::LEN_ONE;
            if (rcnt_ff + ucfw_pkg::LEN_ONE == rlen_ff) rst_ff <= ucfw_pkg::R_END;
          end
          default: begin
            RX_END_OK <= (rx_b == ucfw_pkg::END_BYTE);
            RX_DROP   <= (rx_b != ucfw_pkg::END_BYTE);
            rst_ff    <= ucfw_pkg::R_HUNT;
          end
        endcase
      end
    end
  end
  assign RX_TYPE   = rtyp_ff;
  assign RX_OPCODE = rop_ff;
  assign RX_LEN    = rlen_ff;

endmodule
`default_nettype wire

// File: core/ucfw_host.sv
// host end: wakes the device, waits for its enable event, frames requests
`timescale 1ns/100ps
`default_nettype none
module ucfw_host (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // link to device
  ucfw_link_if.host        LINK,
  // packet send request
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_TYPE,
  input  wire logic [7:0]  CMD_OPCODE,
  input  wire logic [15:0] CMD_LEN,
  output logic             CMD_READY,
  // payload or raw bytes out
  input  wire logic [7:0]  PAY_DATA,
  input  wire logic        PAY_VALID,
  output logic             PAY_READY,
  // received packets
  output logic             RX_HDR_VALID,
  output logic [7:0]       RX_TYPE,
  output logic [7:0]       RX_OPCODE,
  output logic [15:0]      RX_LEN,
  output logic [7:0]       RX_DATA,
  output logic             RX_DATA_VALID,
  output logic             RX_END_OK,
  output logic             RX_DROP,
  // mode control and status
  input  wire logic        TL_OFF,
  input  wire logic        TRANSPARENT_MODE,
  input  wire logic        SEND_BREAK,
  output logic             LINK_READY
);

  typedef enum logic [1:0] {H_ON, H_OFF, H_WAKE} ucfw_hwake_t;

  ucfw_hwake_t        hst_ff;
  ucfw_pkg::ucfw_tx_t tst_ff;
  ucfw_pkg::ucfw_rx_t rst_ff;
  logic               cts_s1_ff, cts_s2_ff, cts_s3_ff, rts_on_ff, brk_ff, got_en_ff, fire;
  logic [7:0]         typ_ff, op_ff, sum_ff, tx_byte, rtyp_ff, rop_ff, rx_b;
  logic [15:0]        len_ff, cnt_ff, rlen_ff, rcnt_ff, len_c;

  ////////////////////////////////////////////////////////////////////////
  // cts pin synchroniser; third stage only feeds the edge detector
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cts_s1_ff <= 1'b1;
      cts_s2_ff <= 1'b1;
      cts_s3_ff <= 1'b1;
    end else begin
      cts_s1_ff <= LINK.dev_rts_n;
      cts_s2_ff <= cts_s1_ff;
      cts_s3_ff <= cts_s2_ff;
    end
  end

  // wake state; no commands until the enable event is in
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      hst_ff    <= H_ON;
      rts_on_ff <= 1'b1;
    end else begin
      case (hst_ff)
        H_ON: if (TL_OFF) begin
          hst_ff    <= H_OFF;
          rts_on_ff <= 1'b0;
        end
        // edge, not level: device rts still up while it drains must not re-wake us
        H_OFF: if ((cts_s3_ff && !cts_s2_ff) || CMD_VALID) begin
          hst_ff    <= H_WAKE;
          rts_on_ff <= 1'b1;
        end
        H_WAKE: if (got_en_ff) hst_ff <= H_ON;
        default: hst_ff <= H_ON;
      endcase
    end
  end
  assign LINK.host_rts_n = !rts_on_ff;
  assign LINK_READY      = (hst_ff == H_ON);

  // break follows SEND_BREAK on the link, one cycle late, for as long as it is held
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      brk_ff <= 1'b0;
    end else begin
      brk_ff <= SEND_BREAK;
    end
  end
  assign LINK.line_break = brk_ff;

  ////////////////////////////////////////////////////////////////////////
  // transmit framer
  assign CMD_READY = (hst_ff == H_ON) && (tst_ff == ucfw_pkg::T_IDLE) && !TRANSPARENT_MODE;
  assign PAY_READY = (hst_ff == H_ON) && (TRANSPARENT_MODE || tst_ff == ucfw_pkg::T_DATA);
  assign len_c     = (CMD_LEN > ucfw_pkg::MAX_PAYLOAD) ? ucfw_pkg::MAX_PAYLOAD : CMD_LEN;

  always_comb begin
    fire    = 1'b1;
    tx_byte = ucfw_pkg::START_BYTE;
    case (tst_ff)
      ucfw_pkg::T_IDLE: begin
        fire    = (CMD_READY && CMD_VALID) || (PAY_READY && PAY_VALID);
        tx_byte = TRANSPARENT_MODE ? PAY_DATA : ucfw_pkg::START_BYTE;
      end
      ucfw_pkg::T_TYPE: tx_byte = typ_ff;
      ucfw_pkg::T_OP:   tx_byte = op_ff;
      ucfw_pkg::T_LENL: tx_byte = len_ff[7:0];
      ucfw_pkg::T_LENH: tx_byte = len_ff[15:8];
      ucfw_pkg::T_SUM:  tx_byte = sum_ff;
      ucfw_pkg::T_DATA: begin
        fire    = PAY_VALID;
        tx_byte = PAY_DATA;
      end
      ucfw_pkg::T_END:  tx_byte = ucfw_pkg::END_BYTE;
      default:          fire = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tst_ff <= ucfw_pkg::T_IDLE;
      typ_ff <= 8'h00;
      op_ff  <= 8'h00;
      sum_ff <= 8'h00;
      len_ff <= ucfw_pkg::LEN_ZERO;
      cnt_ff <= ucfw_pkg::LEN_ZERO;
    end else begin
      case (tst_ff)
        ucfw_pkg::T_IDLE: if (CMD_READY && CMD_VALID) begin
          tst_ff <= ucfw_pkg::T_TYPE;
          typ_ff <= CMD_TYPE;
          op_ff  <= CMD_OPCODE;
          len_ff <= len_c;
          sum_ff <= ucfw_pkg::hdr_sum(CMD_TYPE, CMD_OPCODE, len_c);
          cnt_ff <= ucfw_pkg::LEN_ZERO;
        end
        ucfw_pkg::T_TYPE: tst_ff <= ucfw_pkg::T_OP;
        ucfw_pkg::T_OP:   tst_ff <= ucfw_pkg::T_LENL;
        ucfw_pkg::T_LENL: tst_ff <= ucfw_pkg::T_LENH;
        ucfw_pkg::T_LENH: tst_ff <= ucfw_pkg::T_SUM;
        ucfw_pkg::T_SUM:  tst_ff <= (len_ff == ucfw_pkg::LEN_ZERO) ? ucfw_pkg::T_END : ucfw_pkg::T_DATA;
        ucfw_pkg::T_DATA: if (PAY_VALID) begin
          cnt_ff <= cnt_ff + ucfw_pkg::LEN_ONE;
          if (cnt_ff + ucfw_pkg::LEN_ONE == len_ff) tst_ff <= ucfw_pkg::T_END;
        end
        default: tst_ff <= ucfw_pkg::T_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      LINK.h2d_byte  <= 8'h00;
      LINK.h2d_valid <= 1'b0;
    end else begin
      LINK.h2d_byte  <= tx_byte;
      LINK.h2d_valid <= fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive parser; also spots the transport-enabled event
  assign rx_b = LINK.d2h_byte;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rst_ff        <= ucfw_pkg::R_HUNT;
      rtyp_ff       <= 8'h00;
      rop_ff        <= 8'h00;
      rlen_ff       <= ucfw_pkg::LEN_ZERO;
      rcnt_ff       <= ucfw_pkg::LEN_ZERO;
      got_en_ff     <= 1'b0;
      RX_HDR_VALID  <= 1'b0;
      RX_DATA       <= 8'h00;
      RX_DATA_VALID <= 1'b0;
      RX_END_OK     <= 1'b0;
      RX_DROP       <= 1'b0;
    end else begin
      RX_HDR_VALID  <= 1'b0;
      RX_DATA_VALID <= 1'b0;
      RX_END_OK     <= 1'b0;
      RX_DROP       <= 1'b0;
      got_en_ff     <= 1'b0;
      if (LINK.d2h_valid && TRANSPARENT_MODE) begin
        RX_DATA       <= rx_b;
        RX_DATA_VALID <= 1'b1;
      end else if (LINK.d2h_valid) begin
        case (rst_ff)
          ucfw_pkg::R_HUNT: if (rx_b == ucfw_pkg::START_BYTE) rst_ff <= ucfw_pkg::R_TYPE;
          ucfw_pkg::R_TYPE: begin
            rtyp_ff <= rx_b;
            rst_ff  <= ucfw_pkg::R_OP;
          end
          ucfw_pkg::R_OP: begin
            rop_ff <= rx_b;
            rst_ff <= ucfw_pkg::R_LENL;
          end
          ucfw_pkg::R_LENL: begin
            rlen_ff[7:0] <= rx_b;
            rst_ff       <= ucfw_pkg::R_LENH;
          end
          ucfw_pkg::R_LENH: begin
            rlen_ff[15:8] <= rx_b;
            rst_ff        <= ucfw_pkg::R_SUM;
          end
          ucfw_pkg::R_SUM: begin
            // device may only send confirms or notifications
            if (rx_b != ucfw_pkg::hdr_sum(rtyp_ff, rop_ff, rlen_ff) || rlen_ff > ucfw_pkg::MAX_PAYLOAD ||
                (rtyp_ff != ucfw_pkg::TYPE_CONFIRM && rtyp_ff != ucfw_pkg::TYPE_NOTIFY)) begin
              RX_DROP <= 1'b1;
              rst_ff  <= ucfw_pkg::R_HUNT;
            end else begin
              RX_HDR_VALID <= 1'b1;
              rcnt_ff      <= ucfw_pkg::LEN_ZERO;
              rst_ff       <= (rlen_ff == ucfw_pkg::LEN_ZERO) ? ucfw_pkg::R_END : ucfw_pkg::R_DATA;
            end
          end
          ucfw_pkg::R_DATA: begin
            RX_DATA       <= rx_b;
            RX_DATA_VALID <= 1'b1;
            rcnt_ff       <= rcnt_ff + ucfw_pkg::LEN_ONE;
            if (rcnt_ff + ucfw_pkg::LEN_ONE == rlen_ff) rst_ff <= ucfw_pkg::R_END;
          end
          default: begin
            RX_END_OK <= (rx_b == ucfw_pkg::END_BYTE);
            RX_DROP   <= (rx_b != ucfw_pkg::END_BYTE);
            got_en_ff <= (rx_b == ucfw_pkg::END_BYTE) && (rtyp_ff == ucfw_pkg::TYPE_NOTIFY) &&
                         (rop_ff == ucfw_pkg::OP_TL_ENABLED);
            rst_ff    <= ucfw_pkg::R_HUNT;
          end
        endcase
      end
    end
  end
  assign RX_TYPE   = rtyp_ff;
  assign RX_OPCODE = rop_ff;
  assign RX_LEN    = rlen_ff;

endmodule
`default_nettype wire

// File: core/ucfw_link_if.sv
// byte-level link between device end and host end, with handshake lines
`timescale 1ns/100ps
`default_nettype none
interface ucfw_link_if;
  logic [7:0] d2h_byte;         // device to host byte
  logic       d2h_valid;        // one-cycle strobe
  logic [7:0] h2d_byte;         // host to device byte
  logic       h2d_valid;        // one-cycle strobe
  logic       dev_rts_n;        // device rts, host cts
  logic       host_rts_n;       // host rts, device cts
  logic       host_wakeup_line; // device wake line to host
  logic       line_break;       // break condition from host

  modport dev  (output d2h_byte, d2h_valid, dev_rts_n, host_wakeup_line,
                input  h2d_byte, h2d_valid, host_rts_n, line_break);
  modport host (input  d2h_byte, d2h_valid, dev_rts_n, host_wakeup_line,
                output h2d_byte, h2d_valid, host_rts_n, line_break);
endinterface
`default_nettype wire

// File: core/ucfw_pkg.sv
// shared constants and helpers for the framed command link and its wake-up handshake
package ucfw_pkg;

  // framing delimiters and packet type codes
  localparam logic [7:0]  START_BYTE    = 8'h02;
  localparam logic [7:0]  END_BYTE      = 8'h03;
  localparam logic [7:0]  TYPE_REQUEST  = 8'h52;
  localparam logic [7:0]  TYPE_CONFIRM  = 8'h43;
  localparam logic [7:0]  TYPE_NOTIFY   = 8'h69;
  localparam logic [7:0]  TYPE_REPLY    = 8'h72;

  // payload limit and length field width
  localparam int          LEN_W         = 16;
  localparam logic [15:0] MAX_PAYLOAD   = 16'h014D;
  localparam logic [15:0] LEN_ONE       = 16'h0001;
  localparam logic [15:0] LEN_ZERO      = 16'h0000;

  // opcode of the transport-enabled event; real value lives in the opcode reference
  localparam logic [7:0]  OP_TL_ENABLED = 8'h00;

  // low byte of the sum of type, opcode and both length bytes
  function automatic logic [7:0] hdr_sum(input logic [7:0] typ, input logic [7:0] op,
                                         input logic [15:0] len);
    logic [9:0] s;
    s = {2'h0, typ} + {2'h0, op} + {2'h0, len[7:0]} + {2'h0, len[15:8]};
    return s[7:0];
  endfunction

  // transmit framer states, shared by both ends
  typedef enum logic [2:0] {
    T_IDLE, T_TYPE, T_OP, T_LENL, T_LENH, T_SUM, T_DATA, T_END
  } ucfw_tx_t;

  // receive parser states, shared by both ends
  typedef enum logic [2:0] {
    R_HUNT, R_TYPE, R_OP, R_LENL, R_LENH, R_SUM, R_DATA, R_END
  } ucfw_rx_t;

endpackage

// File: dv/tb_top.sv
// self-checking bench: device and host ends joined by the link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        CORE_CLK, RESET = 1'b1, ev = 1'b0, cv = 1'b0, td = 1'b0, th = 1'b0, dp = 1'b0, hp = 1'b0;
  logic [7:0]  ty = 8'h00, op = 8'h00;
  logic [15:0] ln = 16'h0000;
  logic [31:0] hq[$], dq[$];
  int          bad_count, cmp_count, e_cnt;
  wire         erdy, crdy, dhv, hhv, deo, heo;
  wire [7:0]   dty, dop, hty, hop;
  wire [15:0]  dln, hln;
  // direction, type, opcode, length asked, length expected; last row is clipped
  logic [51:0] rows [5] = '{52'h0_69_11_0000_0000, 52'h0_43_22_0001_0001, 52'h1_52_33_0002_0002,
                            52'h1_72_44_0000_0000, 52'h0_69_55_014E_014D};
  ucfw_link_if u_ucfw_link_if ();
  ucfw_device u_ucfw_device (.CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(u_ucfw_link_if), .EVT_VALID(ev),
    .EVT_TYPE(ty), .EVT_OPCODE(op), .EVT_LEN(ln), .EVT_READY(erdy), .PAY_DATA(8'hA5), .PAY_VALID(dp),
    .PAY_READY(), .RX_HDR_VALID(dhv), .RX_TYPE(dty), .RX_OPCODE(dop), .RX_LEN(dln), .RX_DATA(),
    .RX_DATA_VALID(), .RX_END_OK(deo), .RX_DROP(), .TL_DISABLE(td), .GO_TRANSPARENT(1'b0),
    .TL_ENABLED(), .TRANSPARENT());
  ucfw_host u_ucfw_host (.CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(u_ucfw_link_if), .CMD_VALID(cv),
    .CMD_TYPE(ty), .CMD_OPCODE(op), .CMD_LEN(ln), .CMD_READY(crdy), .PAY_DATA(8'hA5), .PAY_VALID(hp),
    .PAY_READY(), .RX_HDR_VALID(hhv), .RX_TYPE(hty), .RX_OPCODE(hop), .RX_LEN(hln), .RX_DATA(),
    .RX_DATA_VALID(), .RX_END_OK(heo), .RX_DROP(), .TL_OFF(th), .TRANSPARENT_MODE(1'b0),
    .SEND_BREAK(1'b0), .LINK_READY());
  ucfw_link_assertions u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .d2h_byte(u_ucfw_link_if.d2h_byte),
    .d2h_valid(u_ucfw_link_if.d2h_valid), .dev_rts_n(u_ucfw_link_if.dev_rts_n),
    .host_rts_n(u_ucfw_link_if.host_rts_n), .host_wakeup_line(u_ucfw_link_if.host_wakeup_line));
  ////////////////////////////////////////
  // clock, header log at both ends, hang guard
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    if (hhv) hq.push_back({hty, hop, hln});
    if (dhv) dq.push_back({dty, dop, dln});
    if (heo || deo) e_cnt = e_cnt + 1;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    bad_count++;
    final_report();
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // pop the oldest header logged at one end; empty log gives x
  task automatic hdr(input bit hs, input logic [31:0] e);
    logic [31:0] s;
    s = 'x;
    if (hs && hq.size() > 0) s = hq.pop_front();
    if (!hs && dq.size() > 0) s = dq.pop_front();
    chk("header", e, s);
  endtask
  // request held until the ready seen before the taking edge
  task automatic send(input logic [51:0] r);
    @(negedge CORE_CLK);
    {ty, op, ln} = r[47:16];
    ev = !r[48];
    cv = r[48];
    // payload only at the sending end, so the device cannot wake itself during host traffic
    dp = !r[48];
    hp = r[48];
    repeat (2000) begin
      #1;
      if (r[48] ? crdy : erdy) break;
      @(negedge CORE_CLK);
    end
    @(negedge CORE_CLK);
    ev = 1'b0;
    cv = 1'b0;
  endtask
  task automatic fin(input int n);
    repeat (1000) begin
      @(negedge CORE_CLK);
      if (e_cnt >= n) break;
    end
    chk("end count", n, e_cnt);
    {dp, hp} = 2'h0;
  endtask
  // both sides switch the link off
  task automatic off();
    @(negedge CORE_CLK);
    {td, th} = 2'h3;
    @(negedge CORE_CLK);
    {td, th} = 2'h0;
    repeat (30) begin
      @(negedge CORE_CLK);
      if (u_ucfw_link_if.dev_rts_n === 1'b1) break;
    end
    chk("wake line off", 0, u_ucfw_link_if.host_wakeup_line);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(negedge CORE_CLK);
    RESET = 1'b0;
    foreach (rows[i]) begin
      send(rows[i]);
      fin(i + 1);
      hdr(!rows[i][48], {rows[i][47:32], rows[i][15:0]});
      $display("row %0d done", i);
    end
    off();
    send(rows[2]);
    fin(7);
    hdr(1'b1, {8'h69, ucfw_pkg::OP_TL_ENABLED, 16'h0000});
    hdr(1'b0, 32'h5233_0002);
    $display("host wake done");
    off();
    send(rows[0]);
    fin(9);
    hdr(1'b1, {8'h69, ucfw_pkg::OP_TL_ENABLED, 16'h0000});
    hdr(1'b1, 32'h6911_0000);
    $display("device wake done");
    final_report();
  end
endmodule
`default_nettype wire

// File: dv/ucfw_link_assertions.sv
// checker on the link between the device end and the host end
`timescale 1ns/100ps
`default_nettype none
module ucfw_link_assertions (
  // clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  // device to host traffic and handshake
  input wire logic [7:0] d2h_byte,
  input wire logic       d2h_valid,
  input wire logic       dev_rts_n,
  input wire logic       host_rts_n,
  input wire logic       host_wakeup_line
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic [2:0]  p_ff; // position of next byte
  logic [15:0] n_ff; // payload bytes still due
  logic [7:0]  s_ff; // running header sum
  ////////////////////////////////////////
  // frame tracker; raw transparent bytes would confuse it
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      p_ff <= 3'h0;
      n_ff <= 16'h0000;
      s_ff <= 8'h00;
    end else if (d2h_valid) begin
      p_ff <= (p_ff != 3'h6) ? p_ff + 3'h1 : (n_ff == 16'h0000) ? 3'h0 : 3'h6;
      s_ff <= (p_ff == 3'h0) ? 8'h00 : s_ff + d2h_byte;
      if (p_ff == 3'h3) n_ff[7:0] <= d2h_byte;
      if (p_ff == 3'h4) n_ff[15:8] <= d2h_byte;
      if (p_ff == 3'h6) n_ff <= n_ff - 16'h0001;
    end
  end
  ////////////////////////////////////////
  // layout, codes and wake handshake
  chk_frame_start: assert property (d2h_valid && p_ff == 3'h0 |-> d2h_byte == 8'h02)
    else $error("no start byte");
  chk_type_code: assert property (d2h_valid && p_ff == 3'h1 |-> d2h_byte inside {8'h43, 8'h69})
    else $error("bad type code");
  chk_header_burst: assert property (d2h_valid && p_ff == 3'h0 |=> d2h_valid [*5])
    else $error("header not back to back");
  chk_header_sum: assert property (d2h_valid && p_ff == 3'h5 |-> d2h_byte == s_ff)
    else $error("bad header sum");
  chk_length_cap: assert property (d2h_valid && p_ff == 3'h4 |-> {d2h_byte, n_ff[7:0]} <= 16'h014D)
    else $error("length over limit");
  chk_frame_end: assert property (d2h_valid && p_ff == 3'h6 && n_ff == 16'h0000 |-> d2h_byte == 8'h03)
    else $error("no end byte");
  chk_wake_pair: assert property (host_wakeup_line != dev_rts_n)
    else $error("wake line and rts disagree");
  chk_send_awake: assert property (d2h_valid |-> !dev_rts_n && host_wakeup_line)
    else $error("byte sent while link asleep");
  chk_cts_wake: assert property ($fell(host_rts_n) && dev_rts_n |-> ##[1:6] !dev_rts_n)
    else $error("no wake on cts fall");
endmodule
`default_nettype wire
